// File: shared/pbo_consts.svh
`ifndef PBO_CONSTS_SVH
`define PBO_CONSTS_SVH

// Clock rate and derived microsecond divider
`define PBO_CLK_MHZ        100
`define PBO_US_PER_MS      1000

// Timing figures in their own units
`define PBO_DEB_TIME_MS    16
`define PBO_MIN_PRESS_US   150
`define PBO_POST_RST_US    500
`define PBO_EXT_TIME_MS    9500
`define PBO_BASE_TIME_S    4
`define PBO_MAX_TIME_S     14
`define PBO_MS_PER_S       1000

// Derived counts, in microseconds, milliseconds or seconds
`define PBO_DEB_US  (`PBO_DEB_TIME_MS * `PBO_US_PER_MS)
`define PBO_BASE_MS (`PBO_BASE_TIME_S * `PBO_MS_PER_S)
`define PBO_MAX_SEL (`PBO_MAX_TIME_S - `PBO_BASE_TIME_S)

// Register byte offsets
`define PBO_ADR_CTRL       8'h00
`define PBO_ADR_STAT       8'h04

// Control register fields
`define PBO_CTRL_ORDER     0
`define PBO_CTRL_SCI       1
`define PBO_CTRL_EVT       2
`define PBO_CTRL_SMI       3
`define PBO_CTRL_SEL_LO    4
`define PBO_CTRL_SEL_HI    7

// Status register fields
`define PBO_STAT_STS       0
`define PBO_STAT_LVL       1
`define PBO_STAT_ARMED     2
`define PBO_STAT_WAKE      3

// Reset values
`define PBO_CTRL_RST       4'h0
`define PBO_SEL_RST        4'h0

`endif

// File: shared/pbo_pkg.sv
package pbo_pkg;

	// Platform power state reported by the sequencer
	typedef enum logic [1:0] {
		PS_WORK  = 2'h0,
		PS_SLEEP = 2'h1,
		PS_SOFT  = 2'h2,
		PS_DEEP  = 2'h3
	} pbo_pstate_type;

	// Press tracker, one-hot
	typedef enum logic [3:0] {
		PR_IDLE  = 4'h1,
		PR_PRESS = 4'h2,
		PR_HELD  = 4'h4,
		PR_DONE  = 4'h8
	} pbo_press_type;

endpackage

// File: logic/pbo_sync.sv
// Two-flop synchroniser for the raw button pin
module pbo_sync (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// Data
	input  wire logic dIn,
	output logic      dOut
);

	logic stage1_r;

	// Idle level is high, so both stages reset high
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			stage1_r <= 1'b1;
			dOut     <= 1'b1;
		end else begin
			stage1_r <= dIn;
			dOut     <= stage1_r;
		end
	end

endmodule // pbo_sync

// File: logic/pbo_tick.sv
`include "pbo_consts.svh"

// Microsecond and millisecond enable pulses
module pbo_tick #(
	parameter int CYC_PER_US = `PBO_CLK_MHZ,
	parameter int US_PER_MS  = `PBO_US_PER_MS
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// Enables
	output logic      usTick,
	output logic      msTick
);

	logic [15:0] cycCnt_r;
	logic [15:0] usCnt_r;

	// Cycle divider gives one pulse per microsecond
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			cycCnt_r <= 16'h0000;
			usTick   <= 1'b0;
		end else if (cycCnt_r == 16'(CYC_PER_US - 1)) begin
			cycCnt_r <= 16'h0000;
			usTick   <= 1'b1;
		end else begin
			cycCnt_r <= cycCnt_r + 16'h0001;
			usTick   <= 1'b0;
		end
	end

	// Microsecond divider gives one pulse per millisecond
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			usCnt_r <= 16'h0000;
			msTick  <= 1'b0;
		end else if (usTick && usCnt_r == 16'(US_PER_MS - 1)) begin
			usCnt_r <= 16'h0000;
			msTick  <= 1'b1;
		end else begin
			if (usTick)
				usCnt_r <= usCnt_r + 16'h0001;
			msTick <= 1'b0;
		end
	end

endmodule // pbo_tick

// File: logic/pbo_power_button.sv
// Local design decisions: the placing of the registers and register access over Wishbone.
`include "pbo_consts.svh"

// Function
// [R1] Debounce button input for 16 ms
// [R2] Order zero: act after full debounce
// [R3] Order one: act on raw edge, lockout
// [R4] Hold wake request while stretching runs
// [R5] Stretching lengthens override to nine-ten seconds
// [R6] Wake after stretch; override if still held
// [R7] Extension only after graceful entry paths
// [R8] Override period four to fourteen seconds
// [R9] Extended window ignores selected period
// [R10] Working press raises SMI or SCI
// [R11] Working press processed within 100 us
// [R12] Soft-off or deep-sleep press wakes system
// [R13] Wake needs 150 us minimum press
// [R14] Button released 500 us after reset
// [R15] Post-reset gate same in both orders
// [R16] Mechanical-off presses ignored entirely
// [R17] Held override forces soft-off unconditionally; the code issues it only when powerState is neither PS_SOFT nor PS_DEEP
// [R18] Override may lag up to 1.3 s
// [R19] Level bit: debounced or raw by order
// [R20] Well power loss clears status bit
// [R21] Synchronise input, millisecond timebase
module pbo_power_button #(
	parameter int CYC_PER_US = `PBO_CLK_MHZ,
	parameter int US_PER_MS  = `PBO_US_PER_MS
) (
	// Clock and resume-well reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Button pin and platform state
	input  wire logic        power_button_n,
	input  wire logic        deep_well_power_good,
	input  wire logic [1:0]  powerState,
	input  wire logic        sleepStretchActive,
	input  wire logic        extensionEligible,
	// Requests to the sequencer and event logic
	output logic             smiReq,
	output logic             sciReq,
	output logic             wakeReq,
	output logic             overrideReq
);

	// Debounce length in microsecond ticks; follows the timebase scale
	localparam int DEB_US = `PBO_DEB_TIME_MS * US_PER_MS;

	logic        btnSync;
	logic        usTick;
	logic        msTick;
	logic        debLvl_r;
	logic        syncPrev_r;
	logic        debPrev_r;
	logic [15:0] debCnt_r;
	logic [15:0] lockCnt_r;
	logic [15:0] armCnt_r;
	logic        armed_r;
	logic [15:0] lowUs_r;
	logic [15:0] heldMs_r;
	logic [15:0] thrMs;
	logic        debounce_order_select;
	logic        sci_route_enable;
	logic        button_event_enable;
	logic        global_smi_enable;
	logic [3:0]  override_period_select;
	logic        button_status_bit;
	logic        button_level_bit;
	logic        wakePend_r;
	logic        inG3;
	logic        pressEdge;
	logic        qualify;
	logic        curLvl;
	logic        wbReq;
	logic        wbWr;
	pbo_pkg::pbo_press_type press_r;
	pbo_pkg::pbo_press_type press_nxt;

	// Input synchroniser and timebase
	pbo_sync u_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.dIn     (power_button_n),
		.dOut    (btnSync)          // [R21]
	);

	pbo_tick #(
		.CYC_PER_US (CYC_PER_US),
		.US_PER_MS  (US_PER_MS)
	) u_tick (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.usTick  (usTick),
		.msTick  (msTick)           // [R21]
	);

	// Mechanical-off: no well power, nothing seen or latched
	assign inG3 = !deep_well_power_good; // [R16]

	// Debounce: level must stand unchanged for the full window
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			debLvl_r <= 1'b1;
			debCnt_r <= 16'h0000;
		end else if (btnSync == debLvl_r) begin
			debCnt_r <= 16'h0000;
		end else if (usTick) begin
			if (debCnt_r == 16'(DEB_US - 1)) begin
				debLvl_r <= btnSync;   // [R1]
				debCnt_r <= 16'h0000;
			end else begin
				debCnt_r <= debCnt_r + 16'h0001;
			end
		end
	end

	// Edge history of raw and debounced levels
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			syncPrev_r <= 1'b1;
			debPrev_r  <= 1'b1;
		end else begin
			syncPrev_r <= btnSync;
			debPrev_r  <= debLvl_r;
		end
	end

	// Raw-edge lockout: later falls ignored for the debounce time
	always_ff @(posedge sys_clk) begin
		if (!resetn || inG3) begin
			lockCnt_r <= 16'h0000;
		end else if (pressEdge && debounce_order_select) begin
			lockCnt_r <= 16'(DEB_US);  // [R3]
		end else if (usTick && lockCnt_r != 16'h0000) begin
			lockCnt_r <= lockCnt_r - 16'h0001;
		end
	end

	// Post-reset gate: pin must read released for 500 us first.
	// A press held through reset keeps the block disarmed, which
	// is the documented stall in soft-off.
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			armCnt_r <= 16'h0000;
			armed_r  <= 1'b0;
		end else if (!armed_r) begin
			if (!btnSync)
				armCnt_r <= 16'h0000;     // [R14]
			else if (usTick) begin
				if (armCnt_r == 16'(`PBO_POST_RST_US - 1))
					armed_r <= 1'b1;   // [R15]
				else
					armCnt_r <= armCnt_r + 16'h0001;
			end
		end
	end

	// Press detect depends on the debounce order
	always_comb begin
		if (debounce_order_select) begin
			pressEdge = syncPrev_r && !btnSync &&
				lockCnt_r == 16'h0000;   // [R3]
			curLvl = btnSync;
		end else begin
			pressEdge = debPrev_r && !debLvl_r; // [R2]
			curLvl = debLvl_r;
		end
		pressEdge = pressEdge && armed_r && !inG3; // [R16]
	end

	// Wake qualifies once the minimum press time is met.
	// In order zero the debounce already exceeds it.
	assign qualify = !debounce_order_select ||
		lowUs_r >= 16'(`PBO_MIN_PRESS_US);         // [R13]

	// Override threshold in milliseconds
	always_comb begin
		if (sleepStretchActive && extensionEligible)
			thrMs = 16'(`PBO_EXT_TIME_MS);         // [R5] [R7] [R9]
		else if (override_period_select > 4'(`PBO_MAX_SEL))
			thrMs = 16'(`PBO_MAX_TIME_S * `PBO_MS_PER_S); // [R8]
		else
			thrMs = 16'(`PBO_BASE_MS) +
				16'(override_period_select) *
				16'(`PBO_MS_PER_S);                  // [R8]
	end

	// Press tracker next state
	always_comb begin
		press_nxt = press_r;
		case (press_r)
			pbo_pkg::PR_IDLE: begin
				if (pressEdge)
					press_nxt = pbo_pkg::PR_PRESS;
			end
			pbo_pkg::PR_PRESS: begin
				if (curLvl)
					press_nxt = pbo_pkg::PR_IDLE;   // [R13]
				else if (qualify)
					press_nxt = pbo_pkg::PR_HELD;
			end
			pbo_pkg::PR_HELD: begin
				if (debLvl_r && curLvl)
					press_nxt = pbo_pkg::PR_IDLE;
				else if (!debLvl_r && heldMs_r >= thrMs &&
						powerState != 2'(pbo_pkg::PS_DEEP) &&
						powerState != 2'(pbo_pkg::PS_SOFT))
					press_nxt = pbo_pkg::PR_DONE;   // [R17]
			end
			pbo_pkg::PR_DONE: begin
				if (debLvl_r)
					press_nxt = pbo_pkg::PR_IDLE;
			end
			default: press_nxt = pbo_pkg::PR_IDLE;
		endcase
	end

	// Press tracker state; power loss drops any press
	always_ff @(posedge sys_clk) begin
		if (!resetn || inG3)
			press_r <= pbo_pkg::PR_IDLE;            // [R16]
		else
			press_r <= press_nxt;
	end

	// Low-time counter for the minimum press
	always_ff @(posedge sys_clk) begin
		if (!resetn || press_r != pbo_pkg::PR_PRESS)
			lowUs_r <= 16'h0000;
		else if (usTick && lowUs_r != 16'hFFFF)
			lowUs_r <= lowUs_r + 16'h0001;
	end

	// Hold counter, always on the debounced level.
	// Fires on the exact threshold, well inside the allowed lag.
	always_ff @(posedge sys_clk) begin
		if (!resetn || press_r == pbo_pkg::PR_IDLE || debLvl_r)
			heldMs_r <= 16'h0000;
		else if (msTick && heldMs_r != 16'hFFFF)
			heldMs_r <= heldMs_r + 16'h0001;   // [R18]
	end

	// Working-state event routing, registered one cycle after the press edge
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			smiReq <= 1'b0;
			sciReq <= 1'b0;
		end else begin
			smiReq <= 1'b0;
			sciReq <= 1'b0;
			if (pressEdge && button_event_enable &&
					powerState == 2'(pbo_pkg::PS_WORK)) begin
				if (sci_route_enable)
					sciReq <= 1'b1;             // [R10] [R11]
				else if (global_smi_enable)
					smiReq <= 1'b1;             // [R10]
			end
		end
	end

	// Wake is latched, then released when stretching ends
	always_ff @(posedge sys_clk) begin
		if (!resetn || inG3) begin
			wakePend_r <= 1'b0;
			wakeReq    <= 1'b0;
		end else begin
			wakeReq <= 1'b0;
			if (press_r == pbo_pkg::PR_PRESS &&
					press_nxt == pbo_pkg::PR_HELD &&
					(powerState == 2'(pbo_pkg::PS_SOFT) ||
					powerState == 2'(pbo_pkg::PS_DEEP)))
				wakePend_r <= 1'b1;             // [R12]
			else if (wakePend_r && !sleepStretchActive) begin
				wakePend_r <= 1'b0;             // [R4] [R6]
				wakeReq    <= 1'b1;
			end
		end
	end

	// Override pulse to the sequencer, no processor handshake
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			overrideReq <= 1'b0;
		else
			overrideReq <= press_r == pbo_pkg::PR_HELD &&
				press_nxt == pbo_pkg::PR_DONE;   // [R6] [R17]
	end

	// Status bit: press sets it, write-one clears, set wins
	always_ff @(posedge sys_clk) begin
		if (!resetn || inG3)
			button_status_bit <= 1'b0;          // [R20]
		else if (pressEdge)
			button_status_bit <= 1'b1;
		else if (wbWr && wb_adr_i == `PBO_ADR_STAT && wb_sel_i[0] &&
				wb_dat_i[`PBO_STAT_STS])
			button_status_bit <= 1'b0;
	end

	// Level bit follows the selected view of the pin
	assign button_level_bit = debounce_order_select ?
		btnSync : debLvl_r;                     // [R19]

	// Bus decode; a write lands on the edge that sees ack high
	assign wbReq = wb_cyc_i && wb_stb_i;
	assign wbWr  = wbReq && wb_we_i && wb_ack_o;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge sys_clk) begin
		if (!resetn)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wbReq && !wb_ack_o;
	end

	// Control register, byte lane zero only
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			{global_smi_enable, button_event_enable,
				sci_route_enable, debounce_order_select} <=
				`PBO_CTRL_RST;
			override_period_select <= `PBO_SEL_RST; // [R8]
		end else if (wbWr && wb_adr_i == `PBO_ADR_CTRL &&
				wb_sel_i[0]) begin
			debounce_order_select <= wb_dat_i[`PBO_CTRL_ORDER];
			sci_route_enable      <= wb_dat_i[`PBO_CTRL_SCI];
			button_event_enable   <= wb_dat_i[`PBO_CTRL_EVT];
			global_smi_enable     <= wb_dat_i[`PBO_CTRL_SMI];
			override_period_select <=
				wb_dat_i[`PBO_CTRL_SEL_HI:`PBO_CTRL_SEL_LO];
		end
	end

	// Read data; unmapped addresses read zero
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wbReq && !wb_ack_o) begin
			wb_dat_o <= 32'h0000_0000;
			case (wb_adr_i)
				`PBO_ADR_CTRL: begin
					wb_dat_o[`PBO_CTRL_ORDER] <= debounce_order_select;
					wb_dat_o[`PBO_CTRL_SCI]   <= sci_route_enable;
					wb_dat_o[`PBO_CTRL_EVT]   <= button_event_enable;
					wb_dat_o[`PBO_CTRL_SMI]   <= global_smi_enable;
					wb_dat_o[`PBO_CTRL_SEL_HI:`PBO_CTRL_SEL_LO] <=
						override_period_select;
				end
				`PBO_ADR_STAT: begin
					wb_dat_o[`PBO_STAT_STS]   <= button_status_bit;
					wb_dat_o[`PBO_STAT_LVL]   <= button_level_bit;
					wb_dat_o[`PBO_STAT_ARMED] <= armed_r;
					wb_dat_o[`PBO_STAT_WAKE]  <= wakePend_r;
				end
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

endmodule // pbo_power_button

// File: tb/pbo_power_button_chk.sv
module pbo_power_button_chk #(
	parameter int CYC_PER_US = 100,
	parameter int US_PER_MS = 1000
) (
	// Clock and reset
	input wire logic	sys_clk,
	input wire logic	resetn,
	// Bus
	input wire logic	wb_cyc_i,
	input wire logic	wb_stb_i,
	input wire logic	wb_we_i,
	input wire logic [7:0]	wb_adr_i,
	input wire logic [3:0]	wb_sel_i,
	input wire logic [31:0]	wb_dat_i,
	input wire logic [31:0]	wb_dat_o,
	input wire logic	wb_ack_o,
	// Pin and platform
	input wire logic	power_button_n,
	input wire logic	deep_well_power_good,
	input wire logic [1:0]	powerState,
	input wire logic	sleepStretchActive,
	input wire logic	extensionEligible,
	// Requests
	input wire logic	smiReq,
	input wire logic	sciReq,
	input wire logic	wakeReq,
	input wire logic	overrideReq
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = CYC_PER_US * US_PER_MS;
	int	lowCnt_r;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// Raw low time; only a lower bound, debounce starts later
	always_ff @(posedge sys_clk) begin
		if (!resetn || power_button_n)
			lowCnt_r <= 0;
		else
			lowCnt_r <= lowCnt_r + 1;
	end

	AST_ACK_ONE: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bad ack");
	AST_MECH_OFF: assert property (
		!deep_well_power_good && !$past(deep_well_power_good)
		|-> !(smiReq || sciReq || wakeReq || overrideReq))
		else $error("request unpowered");
	AST_ONE_EVT: assert property (!(smiReq && sciReq))
		else $error("SMI with SCI");
	AST_EVT_WORK: assert property (
		smiReq || sciReq |-> $past(powerState) == 2'h0)
		else $error("event not working");
	AST_WAKE_ST: assert property (
		wakeReq |-> $past(powerState) >= 2'h2)
		else $error("wake bad state");
	AST_WAKE_HOLD: assert property (
		sleepStretchActive && $past(sleepStretchActive) |-> !wakeReq)
		else $error("wake in stretch");
	AST_OVR_ONCE: assert property (
		overrideReq |=> !overrideReq [*8])
		else $error("override repeated");
	AST_OVR_HOLD: assert property (
		overrideReq |-> $past(powerState) <= 2'h1 && lowCnt_r >=
		(sleepStretchActive && extensionEligible ? 9000 : 4000) * MS)
		else $error("override early");

	// Main scenarios reached
	CV_SCI: cover property (sciReq);
	CV_WAKE: cover property (wakeReq);
	CV_OVR: cover property (overrideReq);
endmodule // pbo_power_button_chk

bind pbo_power_button pbo_power_button_chk #(
	.CYC_PER_US(CYC_PER_US),
	.US_PER_MS(US_PER_MS)
) i_chk (.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .power_button_n,
	.deep_well_power_good, .powerState, .sleepStretchActive,
	.extensionEligible, .smiReq, .sciReq, .wakeReq, .overrideReq);

// File: tb/pbo_btn_model.sv
module pbo_btn_model (
	// Clock
	input wire logic	sys_clk,
	// Pin, pulled up when released
	output logic	btnN
);
	timeunit 1ns;
	timeprecision 1ps;

	// Released from time zero keeps the post-reset quiet time
	initial btnN = 1'b1;

	// Low for n cycles, then released for up to 200 cycles.
	// Capping the release keeps long override holds affordable;
	// 200 cycles still outlasts the scaled debounce.
	task automatic press(input int n);
		@(posedge sys_clk);
		btnN <= 1'b0;
		repeat (n) @(posedge sys_clk);
		btnN <= 1'b1;
		repeat (n < 200 ? n : 200) @(posedge sys_clk);
	endtask
endmodule // pbo_btn_model

// File: tb/pbo_power_button_tb_top.sv
`include "pbo_consts.svh"

module pbo_power_button_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Scaled timebase keeps the long holds short: 1 ms is MS cycles
	localparam int CPU = 2;
	localparam int UPM = 2;
	localparam int MS = CPU * UPM;
	localparam logic [7:0] CTL = `PBO_ADR_CTRL;
	localparam logic [7:0] STS = `PBO_ADR_STAT;
	logic	sys_clk = 1'b0;
	logic	resetn = 1'b0;
	logic	wbCyc = 1'b0;
	logic	wbWe = 1'b0;
	logic [7:0]	wbAdr = 8'h00;
	logic [31:0]	wbDatI = 32'h0000_0000;
	logic [31:0]	wbDatO;
	logic	wbAck;
	logic	btnN;
	logic	dwpg = 1'b1;
	logic [1:0]	pState = 2'h0;
	logic	stretch = 1'b0;
	logic	elig = 1'b0;
	wire logic [3:0]	evt;
	logic [31:0]	q;
	int	nEv[4];
	int	tEv[4];
	int	cyc = 0;
	int	tPress = 0;
	int	nFail = 0;
	int	cmpCount = 0;

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	pbo_btn_model i_btn (.sys_clk(sys_clk), .btnN(btnN));

	pbo_power_button #(.CYC_PER_US(CPU), .US_PER_MS(UPM)) i_dut (
		.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wbCyc),
		.wb_stb_i(wbCyc), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
		.wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
		.wb_ack_o(wbAck), .power_button_n(btnN),
		.deep_well_power_good(dwpg), .powerState(pState),
		.sleepStretchActive(stretch), .extensionEligible(elig),
		.smiReq(evt[3]), .sciReq(evt[2]), .wakeReq(evt[1]),
		.overrideReq(evt[0]));

	// Tally pulses: 3 smi, 2 sci, 1 wake, 0 override; ceiling cuts hangs
	always @(posedge sys_clk) begin
		cyc++;
		for (int i = 0; i < 4; i++)
			if (evt[i] === 1'b1) begin
				nEv[i]++;
				tEv[i] = cyc;
			end
		if (cyc == 100000) begin
			nFail++;
			closeOut();
		end
	end

	task automatic check(input logic [31:0] seen,
			input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			nFail++;
			$display("unexpected at %0t: got %h want %h",
				$time, seen, exp);
		end
	endtask

	task automatic span(input int v, input int lo, input int hi);
		check({31'h0000_0000, v >= lo && v <= hi}, 32'h0000_0001);
	endtask

	// Classic cycle held until ack is sampled high
	task automatic xfer(input logic we, input logic [7:0] a,
			input logic [7:0] d);
		@(posedge sys_clk);
		wbCyc <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbDatI <= {24'h00_0000, d};
		@(posedge sys_clk);
		while (wbAck !== 1'b1)
			@(posedge sys_clk);
		q = wbDatO;
		wbCyc <= 1'b0;
	endtask

	// Upper bytes must always read zero
	task automatic rd(input logic [7:0] a, input logic [7:0] m,
			input logic [7:0] e);
		xfer(1'b0, a, 8'h00);
		check(q & {24'hFF_FFFF, m}, {24'h00_0000, e});
	endtask

	// k presses of n cycles, then long enough for release to settle.
	// Ends on a rising edge so later drives stay on that edge.
	task automatic hold(input int n, input int k);
		for (int i = 0; i < 4; i++)
			nEv[i] = 0;
		tPress = cyc;
		repeat (k) i_btn.press(n);
		repeat (100) @(posedge sys_clk);
	endtask

	// Override must land between lo and lo plus 1.3 s of holding
	task automatic ovr(input logic [7:0] c, input logic s, input int lo);
		xfer(1'b1, CTL, c);
		stretch <= s;
		hold(lo * MS + 5400, 1);
		check(nEv[0], 1);
		span(tEv[0] - tPress, lo * MS, (lo + 1300) * MS);
	endtask

	task automatic closeOut();
		$display("comparisons %0d mismatches %0d", cmpCount, nFail);
		if (nFail == 0 && cmpCount > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(CTL, 8'hFF, 8'h00);
		rd(STS, 8'h01, 8'h00);
		rd(8'h08, 8'hFF, 8'h00);
		repeat (1100) @(posedge sys_clk);
		rd(STS, 8'h04, 8'h04);
		xfer(1'b1, CTL, 8'h07);
		rd(CTL, 8'hFF, 8'h07);
		hold(10, 2);
		check(nEv[2], 1);
		span(tEv[2] - tPress, 0, 200);
		rd(STS, 8'h01, 8'h01);
		xfer(1'b1, STS, 8'h01);
		rd(STS, 8'h01, 8'h00);
		xfer(1'b1, CTL, 8'h0D);
		hold(10, 1);
		check(nEv[3], 1);
		xfer(1'b1, CTL, 8'h06);
		hold(40, 1);
		check(nEv[2], 0);
		hold(80, 1);
		check(nEv[2], 1);
		span(tEv[2] - tPress, 16 * MS, 16 * MS + 200);
		xfer(1'b1, CTL, 8'h01);
		pState <= 2'h1;
		hold(400, 1);
		check(nEv[1], 0);
		for (int s = 2; s < 4; s++) begin
			pState <= 2'(s);
			hold(200, 1);
			check(nEv[1], 0);
			stretch <= 1'b1;
			fork
				hold(900, 1);
				begin
					repeat (500) @(posedge sys_clk);
					check(nEv[1], 0);
					rd(STS, 8'h0A, 8'h08);
					stretch <= 1'b0;
				end
			join
			check(nEv[1], 1);
		end
		pState <= 2'h0;
		ovr(8'h00, 1'b0, 4000);
		ovr(8'h00, 1'b1, 4000);
		elig <= 1'b1;
		ovr(8'h10, 1'b1, 9000);
		rd(STS, 8'h01, 8'h01);
		pState <= 2'h2;
		dwpg <= 1'b0;
		hold(400, 1);
		check(nEv[1], 0);
		dwpg <= 1'b1;
		rd(STS, 8'h01, 8'h00);
		closeOut();
	end
endmodule // pbo_power_button_tb_top
